// [core/aclass_cfg.svh]
// offsets, reset values, opcodes and field positions of the exec block
`ifndef ACLASS_CFG_SVH
`define ACLASS_CFG_SVH
`define ACLASS_OFF_CTRL 8'h00
`define ACLASS_OFF_STATUS 8'h04
`define ACLASS_OFF_MASK 8'h08
`define ACLASS_OFF_LAST_VEC 8'h0c
`define ACLASS_CTRL_RST 1'h0
`define ACLASS_MASK_RST 3'h0
`define ACLASS_EV_ASSERT 0
`define ACLASS_EV_CALL 1
`define ACLASS_EV_CLASS 2
`define ACLASS_OPC_SLT 8'h50
`define ACLASS_OPC_ULT 8'h52
`define ACLASS_OPC_NEQ 8'h72
`define ACLASS_OPC_CALL 8'ha8
`define ACLASS_OPC_INDIRECT_SUBROUTINE_CALL 8'hc8
`define ACLASS_OPC_CLASS 8'he6
`define ACLASS_CLASS_TRAP_VEC 8'h20
`define ACLASS_RET_OFS 32'h8
`define ACLASS_FS_SINGLE 2'h1
`define ACLASS_FS_DOUBLE 2'h2
`define ACLASS_RESP_OKAY 2'h0
`define ACLASS_RESP_SLVERR 2'h2
`endif

// [core/aclass_pkg.sv]
// types shared by the assert, call and classify exec block
package aclass_pkg;
   typedef enum logic [2:0]
   {
      K_NONE = 3'h0,
      K_SLT = 3'h1,
      K_ULT = 3'h3,
      K_NEQ = 3'h2,
      K_CALL = 3'h6,
      K_INDIRECT_SUBROUTINE_CALL = 3'h7,
      K_CLASS = 3'h5
   } op_kind_t;
   typedef enum logic [1:0]
   {
      R_CTRL = 2'h0,
      R_STATUS = 2'h1,
      R_MASK = 2'h3,
      R_LAST_VEC = 2'h2
   } reg_idx_t;
endpackage

// [core/assert_call_classify_exec.sv]
// exec stage for compare-and-trap, subroutine call and float classify
`timescale 1ns/100ps
`include "aclass_cfg.svh"

module assert_call_classify_exec #(
   parameter int ADDR_W = 8
)
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire logic [31:0] i_instr,
   input wire logic [31:0] i_pc,
   output logic [7:0] o_rf_rd_addr_a,
   output logic [7:0] o_rf_rd_addr_b,
   output logic [7:0] o_rf_rd_addr_twin,
   input wire logic [31:0] i_rf_a_data,
   input wire logic [31:0] i_rf_b_data,
   input wire logic [31:0] i_rf_twin_data,
   output logic o_rf_wr_en,
   output logic [7:0] o_rf_wr_addr,
   output logic [31:0] o_rf_wr_data,
   output logic o_trap,
   output logic [7:0] o_trap_vector,
   output logic o_fetch_redirect,
   output logic [31:0] o_fetch_target,
   output logic o_irq,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready
);

   function automatic aclass_pkg::op_kind_t decode_op(input logic [7:0] op);
      aclass_pkg::op_kind_t k;
      k = aclass_pkg::K_NONE;
      if (op[7:1] == `ACLASS_OPC_SLT >> 1)
         k = aclass_pkg::K_SLT;
      else if (op[7:1] == `ACLASS_OPC_ULT >> 1)
         k = aclass_pkg::K_ULT;
      else if (op[7:1] == `ACLASS_OPC_NEQ >> 1)
         k = aclass_pkg::K_NEQ;
      else if (op[7:1] == `ACLASS_OPC_CALL >> 1)
         k = aclass_pkg::K_CALL;
      else if (op == `ACLASS_OPC_INDIRECT_SUBROUTINE_CALL)
         k = aclass_pkg::K_INDIRECT_SUBROUTINE_CALL;
      else if (op == `ACLASS_OPC_CLASS)
         k = aclass_pkg::K_CLASS;
      return k;
   endfunction

   // exponent-fraction category from format-neutral flags
   function automatic logic [4:0] efc_of(input logic e_zero, input logic e_one,
      input logic e_max, input logic e_inf, input logic f_zero, input logic f_ones,
      input logic f_msb);
      logic [1:0] sub;
      logic [2:0] grp;
      sub = f_zero ? 2'h0 : (f_ones ? 2'h3 : 2'h2);
      grp = e_zero ? 3'h0 : (e_one ? 3'h1 : (e_max ? 3'h3 : 3'h2));
      if (e_inf)
         return f_zero ? 5'h10 : (f_msb ? 5'h13 : 5'h12);
      return {grp, sub};
   endfunction

   // unmapped addresses come back as 1'b0 in bit 2
   function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
      logic [2:0] s;
      s = 3'h0;
      case (a)
         `ACLASS_OFF_CTRL: s = {1'b1, aclass_pkg::R_CTRL};
         `ACLASS_OFF_STATUS: s = {1'b1, aclass_pkg::R_STATUS};
         `ACLASS_OFF_MASK: s = {1'b1, aclass_pkg::R_MASK};
         `ACLASS_OFF_LAST_VEC: s = {1'b1, aclass_pkg::R_LAST_VEC};
         default: s = 3'h0;
      endcase
      return s;
   endfunction

   logic ex_valid_reg;
   logic [31:0] ins_reg;
   logic [31:0] pc_reg;
   logic pend_reg;
   logic [31:0] pend_tgt_reg;
   logic ctrl_reg;
   logic [2:0] status_reg;
   logic [2:0] mask_reg;
   logic [2:0] status_next;

   // execute stage decode
   wire aclass_pkg::op_kind_t kind = decode_op(ins_reg[31:24]);
   wire imm_mode = ins_reg[24];
   wire [1:0] fs = ins_reg[1:0];
   wire [7:0] vec_field = ins_reg[23:16];
   wire [31:0] op_b = imm_mode ? {24'h0, ins_reg[7:0]} : i_rf_b_data;
   wire is_slt = kind == aclass_pkg::K_SLT;
   wire is_ult = kind == aclass_pkg::K_ULT;
   wire is_neq = kind == aclass_pkg::K_NEQ;
   wire is_indirect_subroutine_call = kind == aclass_pkg::K_INDIRECT_SUBROUTINE_CALL;
   wire is_class = kind == aclass_pkg::K_CLASS;
   wire slt_ok = $signed(i_rf_a_data) < $signed(op_b);
   wire ult_ok = i_rf_a_data < op_b;
   wire neq_ok = i_rf_a_data != op_b;
   wire assert_fail = ex_valid_reg && ((is_slt && !slt_ok) || (is_ult && !ult_ok)
      || (is_neq && !neq_ok));
   // only 01 and 10 are executable formats
   wire fs_ok = fs == `ACLASS_FS_SINGLE || fs == `ACLASS_FS_DOUBLE;
   // trap unless hardware classify enabled; reserved formats trap too
   wire class_trap = ex_valid_reg && is_class && (!ctrl_reg || !fs_ok);
   wire class_exec = ex_valid_reg && is_class && ctrl_reg && fs_ok;
   wire call_any = ex_valid_reg && (kind == aclass_pkg::K_CALL || is_indirect_subroutine_call);

   wire [15:0] off16 = {ins_reg[23:16], ins_reg[7:0]};
   wire [29:0] off30 = imm_mode ? {14'h0, off16} : {{14{off16[15]}}, off16};
   wire [29:0] word_tgt = imm_mode ? off30 : off30 + pc_reg[31:2];
   // indirect target is the second register
   wire [31:0] call_tgt = is_indirect_subroutine_call ? i_rf_b_data : {word_tgt, 2'h0};
   wire [31:0] ret_addr = pc_reg + `ACLASS_RET_OFS;

   // double joins the register and its twin
   wire is_dbl = fs == `ACLASS_FS_DOUBLE;
   wire [7:0] s_exp = i_rf_a_data[30:23];
   wire [10:0] d_exp = i_rf_a_data[30:20];
   wire [22:0] s_frac = i_rf_a_data[22:0];
   wire [51:0] d_frac = {i_rf_a_data[19:0], i_rf_twin_data};
   wire e_zero = is_dbl ? d_exp == 11'h0 : s_exp == 8'h0;
   wire e_one = is_dbl ? d_exp == 11'h1 : s_exp == 8'h1;
   wire e_max = is_dbl ? d_exp == 11'h7fe : s_exp == 8'hfe;
   wire e_inf = is_dbl ? &d_exp : &s_exp;
   wire f_zero = is_dbl ? d_frac == 52'h0 : s_frac == 23'h0;
   wire f_ones = is_dbl ? &d_frac : &s_frac;
   wire f_msb = is_dbl ? d_frac[51] : s_frac[22];
   wire [4:0] efc = efc_of(e_zero, e_one, e_max, e_inf, f_zero, f_ones, f_msb);
   // upper bits zero, sign in bit 5
   wire [31:0] class_res = {26'h0, i_rf_a_data[31], efc};

   // classify result into the result register
   wire [31:0] wr_data = is_class ? class_res : ret_addr;
   wire [7:0] wr_addr = is_class ? ins_reg[23:16] : ins_reg[15:8];
   wire [2:0] events = {class_trap, call_any, assert_fail};

   // register bus decode
   wire wr_go = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
   wire rd_go = i_arvalid && !o_arready && !o_rvalid;
   wire [2:0] wsel = reg_sel(i_awaddr);
   wire [2:0] rsel = reg_sel(i_araddr);
   wire wr_hit = o_awready && wsel[2] && i_wstrb[0];
   wire wr_ctrl = wr_hit && wsel[1:0] == aclass_pkg::R_CTRL;
   wire wr_mask = wr_hit && wsel[1:0] == aclass_pkg::R_MASK;
   wire [2:0] w1c = (wr_hit && wsel[1:0] == aclass_pkg::R_STATUS) ? i_wdata[2:0] : 3'h0;
   wire [31:0] rd_mux = !rsel[2] ? 32'h0 :
      rsel[1:0] == aclass_pkg::R_CTRL ? {31'h0, ctrl_reg} :
      rsel[1:0] == aclass_pkg::R_STATUS ? {29'h0, status_reg} :
      rsel[1:0] == aclass_pkg::R_MASK ? {29'h0, mask_reg} :
      {24'h0, o_trap_vector};

   // set wins over a clear in the same cycle
   always_comb
   begin
      status_next = (status_reg & ~w1c) | events;
   end

   // fetch stage: latch instruction and issue register reads
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ex_valid_reg <= 1'b0;
         ins_reg <= 32'h0;
         pc_reg <= 32'h0;
         o_rf_rd_addr_a <= 8'h0;
         o_rf_rd_addr_b <= 8'h0;
         o_rf_rd_addr_twin <= 8'h0;
      end
      else
      begin
         ex_valid_reg <= i_instr_valid;
         ins_reg <= i_instr;
         pc_reg <= i_pc;
         o_rf_rd_addr_a <= i_instr[15:8];
         o_rf_rd_addr_b <= i_instr[7:0];
         o_rf_rd_addr_twin <= {i_instr[15:9], ~i_instr[8]};
      end
   end

   // execute results; no processor flags are produced here
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_rf_wr_en <= 1'b0;
         o_rf_wr_addr <= 8'h0;
         o_rf_wr_data <= 32'h0;
         o_trap <= 1'b0;
         o_trap_vector <= 8'h0;
      end
      else
      begin
         o_rf_wr_en <= call_any || class_exec;
         o_rf_wr_addr <= wr_addr;
         o_rf_wr_data <= wr_data;
         o_trap <= assert_fail || class_trap;
         // assert vector from its field, classify trap uses the fixed vector; last vector held for software
         if (assert_fail || class_trap)
            o_trap_vector <= class_trap ? `ACLASS_CLASS_TRAP_VEC : vec_field;
      end
   end

   // redirect waits for the delay slot so its instruction still runs
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         pend_reg <= 1'b0;
         pend_tgt_reg <= 32'h0;
         o_fetch_redirect <= 1'b0;
         o_fetch_target <= 32'h0;
      end
      else
      begin
         // release after delay slot, same for indirect
         o_fetch_redirect <= ex_valid_reg && pend_reg;
         if (ex_valid_reg && pend_reg)
            o_fetch_target <= pend_tgt_reg;
         if (ex_valid_reg)
            pend_reg <= call_any;
         if (call_any)
            pend_tgt_reg <= call_tgt;
      end
   end

   // registers and interrupt
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         ctrl_reg <= `ACLASS_CTRL_RST;
         mask_reg <= `ACLASS_MASK_RST;
         status_reg <= 3'h0;
         o_irq <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_reg <= i_wdata[0];
         if (wr_mask)
            mask_reg <= i_wdata[2:0];
         status_reg <= status_next;
         o_irq <= |(status_reg & mask_reg);
      end
   end

   // bus slave: write waits for both address and data
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= `ACLASS_RESP_OKAY;
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rresp <= `ACLASS_RESP_OKAY;
         o_rdata <= 32'h0;
      end
      else
      begin
         o_awready <= wr_go;
         o_wready <= wr_go;
         if (o_awready)
         begin
            o_bvalid <= 1'b1;
            o_bresp <= wsel[2] ? `ACLASS_RESP_OKAY : `ACLASS_RESP_SLVERR;
         end
         else if (i_bready)
            o_bvalid <= 1'b0;
         o_arready <= rd_go;
         if (o_arready)
         begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= rsel[2] ? `ACLASS_RESP_OKAY : `ACLASS_RESP_SLVERR;
         end
         else if (i_rready)
            o_rvalid <= 1'b0;
      end
   end

   a_slt_trap:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ex_valid_reg && is_slt && !($signed(i_rf_a_data) < $signed(op_b)))
      |=> (o_trap && o_trap_vector == $past(vec_field)))
      else $error("signed assert failed to trap");

   a_ult_pass:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ex_valid_reg && is_ult && i_rf_a_data < op_b && !call_any) |=> !o_trap)
      else $error("unsigned assert trapped wrongly");

   a_neq_trap:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ex_valid_reg && is_neq && i_rf_a_data == op_b) |=> o_trap)
      else $error("unequal assert missed trap");

   a_imm_operand:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ex_valid_reg && is_ult && ins_reg[24] && i_rf_a_data < {24'h0, ins_reg[7:0]})
      |=> !o_trap)
      else $error("immediate operand not zero-extended");

   a_call_ret:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      call_any |=> (o_rf_wr_en && o_rf_wr_data == $past(pc_reg) + 32'h8
      && o_rf_wr_addr == $past(ins_reg[15:8])))
      else $error("call return address wrong");

   // redirect only after the delay slot
   a_call_delay:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      call_any ##1 (ex_valid_reg && !call_any) |=> (o_fetch_redirect
      && o_fetch_target == $past(pend_tgt_reg)))
      else $error("redirect not after delay slot");

   a_indirect_subroutine_call_target:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ex_valid_reg && is_indirect_subroutine_call) |=> pend_tgt_reg == $past(i_rf_b_data))
      else $error("indirect target not second register");

   a_class_shape:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      class_exec |=> (o_rf_wr_data[31:6] == 26'h0
      && o_rf_wr_data[5] == $past(i_rf_a_data[31])))
      else $error("class code shape wrong");

   a_class_trap:
   assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (ex_valid_reg && is_class && !ctrl_reg) |=> (o_trap && !o_rf_wr_en
      && o_trap_vector == `ACLASS_CLASS_TRAP_VEC))
      else $error("classify did not trap");

endmodule

// [verification/assert_call_classify_exec_test.sv]
// self-checking bench for the assert, call and classify exec block
`timescale 1ns/100ps
`include "aclass_cfg.svh"
module assert_call_classify_exec_test;
   typedef struct
   {
      logic [31:0] ins;
      logic [31:0] pc;
      logic [31:0] a;
      logic [31:0] b;
      logic [2:0] f;
      logic [31:0] wd;
      logic [31:0] tg;
   } row_t;
   logic i_clk = 1'b0, i_sys_rst = 1'b1, i_instr_valid = 1'b0;
   logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
   logic [31:0] i_instr = 32'h0, i_pc = 32'h0, i_wdata = 32'h0;
   logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
   logic [3:0] i_wstrb = 4'hf;
   logic [7:0] o_rf_rd_addr_a, o_rf_rd_addr_b, o_rf_rd_addr_twin, o_rf_wr_addr, o_trap_vector;
   logic [31:0] i_rf_a_data, i_rf_b_data, i_rf_twin_data, o_rf_wr_data, o_fetch_target, o_rdata;
   logic o_rf_wr_en, o_trap, o_fetch_redirect, o_irq, o_awready, o_wready, o_bvalid;
   logic o_arready, o_rvalid;
   logic [1:0] o_bresp, o_rresp, rs;
   logic [7:0] s_wa, ev, ea;
   logic [31:0] d, s_wd;
   int failures = 0, n_checks = 0, n_trap = 0, n_wr = 0, n_rd = 0;
   row_t r;
   row_t rows [15];
   assert_call_classify_exec DUT
   (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_instr_valid(i_instr_valid),
      .i_instr(i_instr),
      .i_pc(i_pc),
      .o_rf_rd_addr_a(o_rf_rd_addr_a),
      .o_rf_rd_addr_b(o_rf_rd_addr_b),
      .o_rf_rd_addr_twin(o_rf_rd_addr_twin),
      .i_rf_a_data(i_rf_a_data),
      .i_rf_b_data(i_rf_b_data),
      .i_rf_twin_data(i_rf_twin_data),
      .o_rf_wr_en(o_rf_wr_en),
      .o_rf_wr_addr(o_rf_wr_addr),
      .o_rf_wr_data(o_rf_wr_data),
      .o_trap(o_trap),
      .o_trap_vector(o_trap_vector),
      .o_fetch_redirect(o_fetch_redirect),
      .o_fetch_target(o_fetch_target),
      .o_irq(o_irq),
      .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid),
      .o_awready(o_awready),
      .i_wdata(i_wdata),
      .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid),
      .o_wready(o_wready),
      .o_bresp(o_bresp),
      .o_bvalid(o_bvalid),
      .i_bready(i_bready),
      .i_araddr(i_araddr),
      .i_arvalid(i_arvalid),
      .o_arready(o_arready),
      .o_rdata(o_rdata),
      .o_rresp(o_rresp),
      .o_rvalid(o_rvalid),
      .i_rready(i_rready)
   );
   rf_fetch_model rf
   (
      .i_clk(i_clk),
      .i_addr_a(o_rf_rd_addr_a),
      .i_addr_b(o_rf_rd_addr_b),
      .i_addr_twin(o_rf_rd_addr_twin),
      .o_a(i_rf_a_data),
      .o_b(i_rf_b_data),
      .o_twin(i_rf_twin_data),
      .i_wr_en(o_rf_wr_en),
      .i_wr_addr(o_rf_wr_addr),
      .i_wr_data(o_rf_wr_data),
      .i_redirect(o_fetch_redirect),
      .i_target(o_fetch_target)
   );
   always #25 i_clk = ~i_clk;
   // pulses last one cycle, so the falling edge sees each exactly once
   always @(negedge i_clk)
   begin
      n_trap += int'(o_trap === 1'b1);
      n_rd += int'(o_fetch_redirect === 1'b1);
      n_wr += int'(o_rf_wr_en === 1'b1);
      // write data is not held after the pulse, so take it while it stands
      if (o_rf_wr_en === 1'b1)
      begin
         s_wa = o_rf_wr_addr;
         s_wd = o_rf_wr_data;
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // second word doubles as delay slot after a call
   task exec(input logic [31:0] i1, input logic [31:0] i2, input logic [31:0] p);
      n_trap = 0;
      n_wr = 0;
      n_rd = 0;
      @(posedge i_clk);
      i_instr <= i1;
      i_pc <= p;
      i_instr_valid <= 1'b1;
      @(posedge i_clk);
      i_instr <= i2;
      i_pc <= p + 32'h4;
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      repeat (5) @(posedge i_clk);
   endtask
   // ready is read at the falling edge, the value the next rising edge samples
   task axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic aw_t, w_t, b_t;
      @(posedge i_clk);
      i_awaddr <= a;
      i_wdata <= v;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do
      begin
         @(negedge i_clk);
         aw_t = o_awready;
         w_t = o_wready;
         b_t = o_bvalid;
         resp = o_bresp;
         @(posedge i_clk);
         if (aw_t)
            i_awvalid <= 1'b0;
         if (w_t)
            i_wvalid <= 1'b0;
      end
      while (b_t !== 1'b1);
      i_bready <= 1'b0;
   endtask
   task axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic ar_t, r_t;
      @(posedge i_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do
      begin
         @(negedge i_clk);
         ar_t = o_arready;
         r_t = o_rvalid;
         v = o_rdata;
         resp = o_rresp;
         @(posedge i_clk);
         if (ar_t)
            i_arvalid <= 1'b0;
      end
      while (r_t !== 1'b1);
      i_rready <= 1'b0;
   endtask
   initial
   begin
      rows = '{
         '{{`ACLASS_OPC_SLT, 24'h311020}, 32'h0, 32'hfffffffe, 32'h1, 3'b000, 32'h0, 32'h0},
         '{{`ACLASS_OPC_SLT, 24'h321020}, 32'h0, 32'h1, 32'hfffffffe, 3'b100, 32'h0, 32'h0},
         '{{`ACLASS_OPC_ULT, 24'h331020}, 32'h0, 32'hfffffffe, 32'h1, 3'b100, 32'h0, 32'h0},
         '{{`ACLASS_OPC_ULT + 8'h1, 24'h341006}, 32'h0, 32'h5, 32'h0, 3'b000, 32'h0, 32'h0},
         '{{`ACLASS_OPC_NEQ, 24'h351020}, 32'h0, 32'h7, 32'h7, 3'b100, 32'h0, 32'h0},
         '{{`ACLASS_OPC_SLT + 8'h1, 24'h371080}, 32'h0, 32'h80, 32'h0, 3'b100, 32'h0, 32'h0},
         '{{`ACLASS_OPC_CALL, 24'hff10fe}, 32'h1000, 32'h0, 32'h0, 3'b011, 32'h1008, 32'hff8},
         '{{`ACLASS_OPC_CALL + 8'h1, 24'h801001}, 32'h0, 32'h0, 32'h0, 3'b011, 32'h8, 32'h20004},
         '{{`ACLASS_OPC_INDIRECT_SUBROUTINE_CALL, 24'h001020}, 32'h300, 32'h0, 32'h4444, 3'b011, 32'h308, 32'h4444},
         '{{`ACLASS_OPC_CLASS, 24'h401001}, 32'h0, 32'h80000000, 32'h0, 3'b010, 32'h20, 32'h0},
         '{{`ACLASS_OPC_CLASS, 24'h401002}, 32'h0, 32'h7ff00000, 32'h0, 3'b010, 32'h10, 32'h0},
         '{{`ACLASS_OPC_CLASS, 24'h401001}, 32'h0, 32'h7fc00000, 32'h0, 3'b010, 32'h13, 32'h0},
         '{{`ACLASS_OPC_CLASS, 24'h401001}, 32'h0, 32'h3f800000, 32'h0, 3'b010, 32'h08, 32'h0},
         '{{`ACLASS_OPC_CLASS, 24'h401002}, 32'h0, 32'hfff00000, 32'h1, 3'b010, 32'h32, 32'h0},
         '{{`ACLASS_OPC_CLASS, 24'h401003}, 32'h0, 32'h0, 32'h0, 3'b100, 32'h0, 32'h0}
      };
      repeat (12) @(posedge i_clk);
      check({o_trap, o_rf_wr_en, o_fetch_redirect, o_irq, o_bvalid, o_rvalid}, 32'h0);
      i_sys_rst <= 1'b0;
      axi_rd(`ACLASS_OFF_CTRL, d, rs);
      check(d, `ACLASS_CTRL_RST);
      axi_rd(`ACLASS_OFF_MASK, d, rs);
      check(d, `ACLASS_MASK_RST);
      axi_rd(8'h10, d, rs);
      check({rs, d}, {`ACLASS_RESP_SLVERR, 32'h0});
      axi_wr(8'h14, 32'h1, rs);
      check(rs, `ACLASS_RESP_SLVERR);
      axi_wr(`ACLASS_OFF_CTRL, 32'h1, rs);
      check(rs, `ACLASS_RESP_OKAY);
      foreach (rows[k])
      begin
         r = rows[k];
         rf.mem[8'h10] = r.a;
         rf.mem[8'h20] = r.b;
         rf.mem[8'h11] = r.b;
         exec(r.ins, 32'h0, r.pc);
         ev = (r.ins[31:24] == `ACLASS_OPC_CLASS) ? `ACLASS_CLASS_TRAP_VEC : r.ins[23:16];
         ea = (r.ins[31:24] == `ACLASS_OPC_CLASS) ? r.ins[23:16] : r.ins[15:8];
         check(n_trap, r.f[2]);
         if (r.f[2])
            check(o_trap_vector, ev);
         check(n_wr, r.f[1]);
         if (r.f[1])
         begin
            check(s_wa, ea);
            check(s_wd, r.wd);
         end
         check(n_rd, r.f[0]);
         if (r.f[0])
         begin
            check(o_fetch_target, r.tg);
            check(rf.fetch_pc, r.tg);
         end
      end
      // idle cycles must not use up the delay slot
      rf.mem[8'h20] = 32'h6000;
      n_rd = 0;
      @(posedge i_clk);
      i_instr <= {`ACLASS_OPC_INDIRECT_SUBROUTINE_CALL, 24'h001020};
      i_instr_valid <= 1'b1;
      @(posedge i_clk);
      i_instr_valid <= 1'b0;
      repeat (6) @(posedge i_clk);
      check(n_rd, 32'h0);
      exec(32'h0, 32'h0, 32'h504);
      check(n_rd, 32'h1);
      check(o_fetch_target, 32'h6000);
      check(rf.fetch_pc, 32'h6000);
      // clear old events first, else the interrupt check proves nothing
      axi_wr(`ACLASS_OFF_STATUS, 32'h7, rs);
      axi_wr(`ACLASS_OFF_MASK, 32'h1, rs);
      repeat (2) @(posedge i_clk);
      check(o_irq, 1'b0);
      rf.mem[8'h10] = 32'h5;
      exec({`ACLASS_OPC_ULT + 8'h1, 24'h411000}, {`ACLASS_OPC_NEQ + 8'h1, 24'h421005}, 32'h0);
      check(n_trap, 32'h2);
      check(o_trap_vector, 8'h42);
      check(o_irq, 1'b1);
      axi_rd(`ACLASS_OFF_LAST_VEC, d, rs);
      check(d, 32'h42);
      axi_rd(`ACLASS_OFF_STATUS, d, rs);
      check(d[0], 1'b1);
      axi_wr(`ACLASS_OFF_STATUS, 32'h1, rs);
      repeat (2) @(posedge i_clk);
      check(o_irq, 1'b0);
      axi_wr(`ACLASS_OFF_CTRL, 32'h0, rs);
      exec({`ACLASS_OPC_CLASS, 24'h401001}, 32'h0, 32'h0);
      check(n_trap, 32'h1);
      check(n_wr, 32'h0);
      check(o_trap_vector, `ACLASS_CLASS_TRAP_VEC);
      // mid-run reset brings outputs and control back to defaults
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(negedge i_clk);
      check({o_trap, o_rf_wr_en, o_fetch_redirect, o_irq, o_bvalid, o_rvalid}, 32'h0);
      check(o_trap_vector, 8'h0);
      axi_rd(`ACLASS_OFF_CTRL, d, rs);
      check(d, `ACLASS_CTRL_RST);
      // only the low byte lane writes the control bit
      i_wstrb <= 4'he;
      axi_wr(`ACLASS_OFF_CTRL, 32'h1, rs);
      i_wstrb <= 4'hf;
      axi_rd(`ACLASS_OFF_CTRL, d, rs);
      check(d, `ACLASS_CTRL_RST);
      give_verdict();
   end
   // whole run is well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge i_clk);
      failures++;
      give_verdict();
   end
endmodule

// [verification/rf_fetch_model.sv]
// register file and fetch unit model on the far side of the exec block
`timescale 1ns/100ps
module rf_fetch_model
(
   input wire logic i_clk,
   input wire logic [7:0] i_addr_a,
   input wire logic [7:0] i_addr_b,
   input wire logic [7:0] i_addr_twin,
   output logic [31:0] o_a,
   output logic [31:0] o_b,
   output logic [31:0] o_twin,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_redirect,
   input wire logic [31:0] i_target
);
   logic [31:0] mem [256];
   logic [31:0] fetch_pc = 32'h0;
   // distinct pattern per register so a wrong index shows
   initial
   begin
      for (int k = 0; k < 256; k++)
         mem[k] = {4{k[7:0]}} ^ 32'h5a5aa5a5;
   end
   assign o_a = mem[i_addr_a];
   assign o_b = mem[i_addr_b];
   assign o_twin = mem[i_addr_twin];
   always @(posedge i_clk)
   begin
      if (i_wr_en)
         mem[i_wr_addr] <= i_wr_data;
      if (i_redirect)
         fetch_pc <= i_target;
   end
endmodule
